// [plhc_pkg.sv]
// Package for the power, LED and host configuration register bank
package plhc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] OFS_TAG_INSERT = 8'hc2;
	localparam logic [7:0] OFS_PWR_LED = 8'hc3;
	localparam logic [7:0] OFS_SLEEP_TIMER = 8'hc4;
	localparam logic [7:0] OFS_FWD_HOST = 8'hc6;
	localparam logic [7:0] RST_TAG_INSERT = 8'h00;
	localparam logic [7:0] RST_PWR_LED = 8'h00;
	localparam logic [7:0] RST_SLEEP_TIMER = 8'h50;
	localparam logic [7:0] RST_FWD_HOST = 8'h00;
	localparam logic [7:0] MASK_TAG_INSERT = 8'h3f;
	localparam logic [7:0] MASK_PWR_LED = 8'hff;
	localparam logic [7:0] MASK_FWD_HOST = 8'h7b;
	localparam int BIT_P2_TO_P1 = 3;
	localparam int BIT_P2_TO_P3 = 2;
	localparam int BIT_P3_TO_P1 = 1;
	localparam int BIT_P3_TO_P2 = 0;
	localparam int BIT_CPU_PD = 7;
	localparam int BIT_SW_PD = 6;
	localparam int LED_MODE_LSB = 4;
	localparam int BIT_LED_DEBUG = 3;
	localparam int BIT_PLL_OFF = 2;
	localparam int PM_MODE_LSB = 0;
	localparam int FWD_MASK_LSB = 4;
	localparam int BIT_RMII_CLK = 3;
	localparam int HOST_MODE_LSB = 0;
	localparam int CLK_HZ = 20000000;
	localparam int SLEEP_UNIT_MS = 20;
	localparam int SLEEP_UNIT_CYC = CLK_HZ / 1000 * SLEEP_UNIT_MS;
	localparam int BLINK_MS = 100;
	localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	typedef enum logic [1:0]
	{
		PLHC_LED_LA_SPD = 2'b00,
		PLHC_LED_LNK_ACT = 2'b01,
		PLHC_LED_LA_DUP = 2'b10,
		PLHC_LED_LNK_DUP = 2'b11
	} plhc_led_mode_t;
	typedef enum logic [1:0]
	{
		PLHC_PM_NORMAL = 2'b00,
		PLHC_PM_ENERGY = 2'b01,
		PLHC_PM_SW_PD = 2'b10,
		PLHC_PM_SAVE = 2'b11
	} plhc_pm_mode_t;
	typedef enum logic [1:0]
	{
		PLHC_ED_AWAKE = 2'b00,
		PLHC_ED_COUNT = 2'b01,
		PLHC_ED_ASLEEP = 2'b10
	} plhc_ed_state_t;
endpackage : plhc_pkg

// [plhc_sleep_if.sv]
// Interface between the register bank and the sleep timer
`timescale 1ns/10ps
interface plhc_sleep_if;
	logic enable;
	logic [7:0] units;
	logic energy;
	logic asleep;
	modport bank (output enable, output units, output energy, input asleep);
	modport timer (input enable, input units, input energy, output asleep);
endinterface : plhc_sleep_if

// [plhc_sleep_timer.sv]
// Energy-detect sleep timer
`timescale 1ns/10ps
module plhc_sleep_timer
	import plhc_pkg::*;
#(
	parameter int UNIT_CYC = SLEEP_UNIT_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	plhc_sleep_if.timer sl
);
	plhc_ed_state_t state;
	plhc_ed_state_t next_state;
	logic [19:0] tick_cnt;
	logic [7:0] unit_cnt;
	wire tick = (tick_cnt == 20'(UNIT_CYC - 1));
	wire done = tick && (unit_cnt + 8'h01 >= sl.units);
	always_comb
	begin
		next_state = state;
		case (state)
			PLHC_ED_AWAKE: if (sl.enable && !sl.energy) next_state = PLHC_ED_COUNT;
			PLHC_ED_COUNT:
			begin
				if (!sl.enable || sl.energy) next_state = PLHC_ED_AWAKE;
				else if (done || sl.units == 8'h00) next_state = PLHC_ED_ASLEEP;
			end
			PLHC_ED_ASLEEP: if (!sl.enable || sl.energy) next_state = PLHC_ED_AWAKE;
			default: next_state = PLHC_ED_AWAKE;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= PLHC_ED_AWAKE;
			tick_cnt <= 20'h00000;
			unit_cnt <= 8'h00;
		end
		else
		begin
			state <= next_state;
			// Any energy restarts the quiet period from zero
			if (next_state != PLHC_ED_COUNT)
			begin
				tick_cnt <= 20'h00000;
				unit_cnt <= 8'h00;
			end
			else if (tick)
			begin
				tick_cnt <= 20'h00000;
				unit_cnt <= unit_cnt + 8'h01;
			end
			else
				tick_cnt <= tick_cnt + 20'h00001;
		end
	end
	assign sl.asleep = (state == PLHC_ED_ASLEEP);
endmodule : plhc_sleep_timer

// [plhc_regs.sv]
// Power, LED and host configuration register bank
// Function
// - Bits 3,2 insert port 2 default tag at egress ports 1 and 3
// - Bits 1,0 insert port 3 default tag at egress ports 1 and 2; reset zero
// - Bit 7 enables CPU interface clock tree power-down; resets disabled
// - Bit 6 enables switch core clock tree power-down; resets disabled
// - LED mode field picks functions of both indicator pins; resets 00
// - Indicators active low: link, 100M, full duplex low; activity blinks
// - Debug bit drives inverted energy onto pin b, inverted ready onto a
// - Bit 2 allows PLL power-down; resets zero
// - Power mode field: normal, energy detect, power-down, saving; resets normal
// - Invalid VLAN ID frames go to three-bit port mask; resets zero
// - Host interface mode field resets from port 2 indicator strap levels
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module plhc_regs
	import plhc_pkg::*;
#(
	parameter int UNIT_CYC = SLEEP_UNIT_CYC,
	parameter int BLINK_PERIOD = BLINK_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [plhc_pkg::ADDR_W-1:0] addr,
	input wire logic [plhc_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [plhc_pkg::DATA_W-1:0] rdata,
	input wire logic port2_indicator_a_strap,
	input wire logic port2_indicator_b_strap,
	input wire logic link_up,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic activity,
	input wire logic energy_detect,
	input wire logic device_ready,
	output logic src2_tag_at_p1,
	output logic src2_tag_at_p3,
	output logic src3_tag_at_p1,
	output logic src3_tag_at_p2,
	output logic cpu_clk_pd_en,
	output logic sw_clk_pd_en,
	output logic pll_off_en,
	output logic [1:0] pm_mode,
	output logic low_power,
	output logic [2:0] invalid_vid_fwd_mask,
	output logic rmii_clk_internal,
	output logic [1:0] host_mode,
	output logic indicator_pin_a_n,
	output logic indicator_pin_b_n
);
	import plhc_pkg::*;

	logic rst_meta;
	logic rst_sync;
	logic [7:0] reg_tag;
	logic [7:0] reg_pwr;
	logic [7:0] reg_sleep;
	logic [7:0] reg_fwd;
	logic strap_taken;
	logic blink;
	logic [23:0] blink_cnt;

	plhc_sleep_if sl();

	function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction : merge

	// Reset released through two flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	wire hit_tag = (addr == OFS_TAG_INSERT);
	wire hit_pwr = (addr == OFS_PWR_LED);
	wire hit_sleep = (addr == OFS_SLEEP_TIMER);
	wire hit_fwd = (addr == OFS_FWD_HOST);
	wire [7:0] rd_mux = hit_tag ? reg_tag :
		hit_pwr ? reg_pwr :
		hit_sleep ? reg_sleep :
		hit_fwd ? reg_fwd : 8'h00;

	// Reserved bits are masked, so they always read their defaults
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			reg_tag <= RST_TAG_INSERT;
			reg_pwr <= RST_PWR_LED;
			reg_sleep <= RST_SLEEP_TIMER;
			reg_fwd <= RST_FWD_HOST;
			strap_taken <= 1'b0;
		end
		else
		begin
			if (wr && hit_tag)
				reg_tag <= merge(reg_tag, wdata, MASK_TAG_INSERT);
			if (wr && hit_pwr)
				reg_pwr <= merge(reg_pwr, wdata, MASK_PWR_LED);
			if (wr && hit_sleep)
				reg_sleep <= wdata;
			// Strap is caught on the first clock after release, not under reset
			if (!strap_taken)
			begin
				reg_fwd[HOST_MODE_LSB +: 2] <= {port2_indicator_b_strap,
					port2_indicator_a_strap};
				strap_taken <= 1'b1;
			end
			else if (wr && hit_fwd)
				reg_fwd <= merge(reg_fwd, wdata, MASK_FWD_HOST);
		end
	end

	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
			rdata <= 8'h00;
		else if (rd)
			rdata <= rd_mux;
	end

	// Configuration outputs, registered once more to keep them on flops
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			src2_tag_at_p1 <= 1'b0;
			src2_tag_at_p3 <= 1'b0;
			src3_tag_at_p1 <= 1'b0;
			src3_tag_at_p2 <= 1'b0;
			cpu_clk_pd_en <= 1'b0;
			sw_clk_pd_en <= 1'b0;
			pll_off_en <= 1'b0;
			pm_mode <= 2'b00;
			invalid_vid_fwd_mask <= 3'h0;
			rmii_clk_internal <= 1'b0;
			host_mode <= 2'b00;
			low_power <= 1'b0;
		end
		else
		begin
			src2_tag_at_p1 <= reg_tag[BIT_P2_TO_P1];
			src2_tag_at_p3 <= reg_tag[BIT_P2_TO_P3];
			src3_tag_at_p1 <= reg_tag[BIT_P3_TO_P1];
			src3_tag_at_p2 <= reg_tag[BIT_P3_TO_P2];
			cpu_clk_pd_en <= reg_pwr[BIT_CPU_PD];
			sw_clk_pd_en <= reg_pwr[BIT_SW_PD];
			pll_off_en <= reg_pwr[BIT_PLL_OFF];
			pm_mode <= reg_pwr[PM_MODE_LSB +: 2];
			invalid_vid_fwd_mask <= reg_fwd[FWD_MASK_LSB +: 3];
			rmii_clk_internal <= reg_fwd[BIT_RMII_CLK];
			host_mode <= reg_fwd[HOST_MODE_LSB +: 2];
			low_power <= sl.asleep;
		end
	end

	assign sl.enable = (reg_pwr[PM_MODE_LSB +: 2] == PLHC_PM_ENERGY);
	assign sl.units = reg_sleep;
	assign sl.energy = energy_detect;

	plhc_sleep_timer #(.UNIT_CYC(UNIT_CYC)) u_timer
	(
		.clk(clk),
		.rst_n(rst_sync),
		.sl(sl)
	);

	// Blink clock; shown only while activity is present
	wire blink_wrap = (blink_cnt == 24'(BLINK_PERIOD - 1));
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			blink_cnt <= 24'h000000;
			blink <= 1'b0;
		end
		else if (blink_wrap)
		begin
			blink_cnt <= 24'h000000;
			blink <= ~blink;
		end
		else
			blink_cnt <= blink_cnt + 24'h000001;
	end

	wire [1:0] led_mode = reg_pwr[LED_MODE_LSB +: 2];
	// Active-high "on" levels; the pins invert them
	wire on_link_act = link_up && !(activity && blink);
	wire on_act = activity && blink;
	wire on_a = (led_mode == PLHC_LED_LNK_ACT || led_mode == PLHC_LED_LNK_DUP) ?
		link_up : on_link_act;
	wire on_b = (led_mode == PLHC_LED_LA_SPD) ? (link_up && speed_100) :
		(led_mode == PLHC_LED_LNK_ACT) ? on_act :
		(link_up && full_duplex);
	wire dbg = reg_pwr[BIT_LED_DEBUG];

	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			indicator_pin_a_n <= 1'b1;
			indicator_pin_b_n <= 1'b1;
		end
		else
		begin
			indicator_pin_a_n <= dbg ? ~device_ready : ~on_a;
			indicator_pin_b_n <= dbg ? ~energy_detect : ~on_b;
		end
	end
endmodule : plhc_regs

// [plhc_regs_checker.sv]
// Checker for the power, LED and host register bank
`timescale 1ns/10ps
module plhc_regs_checker
	import plhc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic src2_tag_at_p1,
	input wire logic src3_tag_at_p2,
	input wire logic cpu_clk_pd_en,
	input wire logic sw_clk_pd_en,
	input wire logic pll_off_en,
	input wire logic [1:0] pm_mode,
	input wire logic [2:0] invalid_vid_fwd_mask
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire w_ins = wr && addr == OFS_TAG_INSERT;
	wire w_pl = wr && addr == OFS_PWR_LED;
	wire w_fh = wr && addr == OFS_FWD_HOST;
	wire r_un = rd && !(addr inside {8'hc2, 8'hc3, 8'hc4, 8'hc6});
	property p_src2; w_ins |-> ##2 src2_tag_at_p1 == $past(wdata[3], 2); endproperty
	a_src2: assert property (p_src2) else $error("src2 insert bit wrong");
	property p_src3; w_ins |-> ##2 src3_tag_at_p2 == $past(wdata[0], 2); endproperty
	a_src3: assert property (p_src3) else $error("src3 insert bit wrong");
	property p_cpu; w_pl |-> ##2 cpu_clk_pd_en == $past(wdata[7], 2); endproperty
	a_cpu: assert property (p_cpu) else $error("cpu power-down enable wrong");
	property p_sw; w_pl |-> ##2 sw_clk_pd_en == $past(wdata[6], 2); endproperty
	a_sw: assert property (p_sw) else $error("switch power-down enable wrong");
	property p_pll; w_pl |-> ##2 pll_off_en == $past(wdata[2], 2); endproperty
	a_pll: assert property (p_pll) else $error("pll off enable wrong");
	property p_pm; w_pl |-> ##2 pm_mode == $past(wdata[1:0], 2); endproperty
	a_pm: assert property (p_pm) else $error("power mode wrong");
	// Mode may only move two cycles after its own write
	property p_pm_hold; !w_pl [*2] |=> $stable(pm_mode); endproperty
	a_pm_hold: assert property (p_pm_hold) else $error("power mode moved alone");
	property p_fwd; w_fh |-> ##2 invalid_vid_fwd_mask == $past(wdata[6:4], 2); endproperty
	a_fwd: assert property (p_fwd) else $error("forward mask wrong");
	property p_unm; r_un |=> rdata == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule : plhc_regs_checker

bind plhc_regs plhc_regs_checker i_plhc_regs_checker (.clk(clk), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .src2_tag_at_p1(src2_tag_at_p1),
	.src3_tag_at_p2(src3_tag_at_p2), .cpu_clk_pd_en(cpu_clk_pd_en),
	.sw_clk_pd_en(sw_clk_pd_en), .pll_off_en(pll_off_en), .pm_mode(pm_mode),
	.invalid_vid_fwd_mask(invalid_vid_fwd_mask));

// [plhc_regs_tb.sv]
// Testbench for the power, LED and host register bank
`timescale 1ns/10ps
module plhc_regs_tb;
	import plhc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic link_up = 1'b1;
	logic speed_100 = 1'b0;
	logic full_duplex = 1'b1;
	logic activity = 1'b0;
	logic energy_detect = 1'b0;
	logic device_ready = 1'b1;
	logic [7:0] rdata;
	logic [3:0] ins;
	logic c_pd, s_pd, pll, lp, rmii, pa, pb;
	logic [1:0] pm_mode;
	logic [1:0] host_mode;
	logic [2:0] fwd;
	int fail_count = 0;
	int total_checks = 0;
	always #25 clk = ~clk;
	plhc_regs #(.UNIT_CYC(10), .BLINK_PERIOD(4)) i_plhc_regs (.clk(clk), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.port2_indicator_a_strap(1'b1), .port2_indicator_b_strap(1'b0), .link_up(link_up),
		.speed_100(speed_100), .full_duplex(full_duplex), .activity(activity),
		.energy_detect(energy_detect), .device_ready(device_ready),
		.src2_tag_at_p1(ins[3]), .src2_tag_at_p3(ins[2]), .src3_tag_at_p1(ins[1]),
		.src3_tag_at_p2(ins[0]), .cpu_clk_pd_en(c_pd), .sw_clk_pd_en(s_pd),
		.pll_off_en(pll), .pm_mode(pm_mode), .low_power(lp), .invalid_vid_fwd_mask(fwd),
		.rmii_clk_internal(rmii), .host_mode(host_mode), .indicator_pin_a_n(pa),
		.indicator_pin_b_n(pb));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("rdata", e, rdata);
		@(posedge clk);
	endtask : rd_chk
	task automatic pause;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask : pause
	task automatic give_verdict;
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		give_verdict();
	end
	initial
	begin
		logic [7:0] d;
		logic [1:0] m;
		logic [1:0] seen;
		int n;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (7) @(posedge clk);
		rd_chk(OFS_TAG_INSERT, RST_TAG_INSERT);
		rd_chk(OFS_PWR_LED, RST_PWR_LED);
		rd_chk(OFS_SLEEP_TIMER, RST_SLEEP_TIMER);
		rd_chk(OFS_FWD_HOST, 8'h01);
		wr_reg(8'hc5, 8'hff);
		rd_chk(8'hc5, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			d = i ? 8'h0a : 8'hff;
			wr_reg(OFS_TAG_INSERT, d);
			rd_chk(OFS_TAG_INSERT, d & MASK_TAG_INSERT);
			chk("ins", {4'h0, d[3:0]}, {4'h0, ins});
		end
		for (int i = 0; i < 4; i++)
		begin
			m = i[1:0];
			d = {m[0], ~m[0], 3'b000, m[0], m};
			wr_reg(OFS_PWR_LED, d);
			rd_chk(OFS_PWR_LED, d);
			chk("pwr", d & 8'hc7, {c_pd, s_pd, 3'b000, pll, pm_mode});
			wr_reg(OFS_PWR_LED, {2'b00, m, 4'h0});
			pause();
			chk("led", {6'h00, ~m[1], 1'b0}, {6'h00, pb, pa});
			@(posedge clk);
		end
		wr_reg(OFS_PWR_LED, 8'h08);
		pause();
		chk("dbg", 8'h02, {6'h00, pb, pa});
		@(posedge clk);
		energy_detect <= 1'b1;
		device_ready <= 1'b0;
		pause();
		chk("dbg", 8'h01, {6'h00, pb, pa});
		@(posedge clk);
		wr_reg(OFS_PWR_LED, 8'h10);
		activity <= 1'b1;
		seen = 2'b00;
		repeat (12)
		begin
			@(negedge clk);
			seen = seen | {pb, ~pb};
		end
		chk("blink", 8'h03, {6'h00, seen});
		@(posedge clk);
		activity <= 1'b0;
		energy_detect <= 1'b0;
		// Speed and duplex levels are otherwise never moved; link drops only for led_nolink
		speed_100 <= 1'b1;
		full_duplex <= 1'b0;
		wr_reg(OFS_PWR_LED, 8'h00);
		pause();
		chk("led_spd", 8'h00, {6'h00, pb, pa});
		@(posedge clk);
		wr_reg(OFS_PWR_LED, 8'h20);
		pause();
		chk("led_dup", 8'h02, {6'h00, pb, pa});
		@(posedge clk);
		link_up <= 1'b0;
		pause();
		chk("led_nolink", 8'h03, {6'h00, pb, pa});
		@(posedge clk);
		link_up <= 1'b1;
		wr_reg(OFS_FWD_HOST, 8'hff);
		rd_chk(OFS_FWD_HOST, MASK_FWD_HOST);
		chk("fwd", 8'h7b, {1'b0, fwd, rmii, 1'b0, host_mode});
		wr_reg(OFS_SLEEP_TIMER, 8'h03);
		rd_chk(OFS_SLEEP_TIMER, 8'h03);
		wr_reg(OFS_PWR_LED, 8'h01);
		n = 0;
		// Sampled between edges, where the flag has settled
		while (lp !== 1'b1 && n < 60)
		begin
			@(negedge clk);
			n++;
		end
		chk("sleep", 8'h01, {7'h00, n >= 26 && n <= 36});
		@(posedge clk);
		energy_detect <= 1'b1;
		pause();
		chk("wake", 8'h00, {7'h00, lp});
		// Second reset in mid-run must restore defaults and take the strap again
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (7) @(posedge clk);
		rd_chk(OFS_TAG_INSERT, RST_TAG_INSERT);
		rd_chk(OFS_PWR_LED, RST_PWR_LED);
		rd_chk(OFS_FWD_HOST, 8'h01);
		chk("host_rst", 8'h01, {6'h00, host_mode});
		chk("lp_rst", 8'h00, {7'h00, lp});
		give_verdict();
	end
endmodule : plhc_regs_tb
